// ### hdl/sci_pkg.sv
// package: constants and types for the indirect switch register bridge
// How it works
// - internal switch registers reached only via data/command pair or direct window
// - system space holds per-port manual flow control 0-2, data/command, MAC address
// - command write with busy set starts single write: address, write, byte enables
// - busy clears when the indirect write has finished
// - sequential write: program auto-step command, then each data write launches a cycle
// - sequential write completion steps the command address up or down
// - direct window write loads mapped address, all enables, write, sets busy
// - window covers only a fixed subset of internal registers
// - command write with busy and read set starts a single read
// - read data valid in data register when busy clears
// - sequential read: auto-step command, busy clears per cycle with data ready
// - host read of data register steps address and launches next read
`default_nettype none
package sci_pkg;
  localparam int unsigned PADDR_W  = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned CADDR_W  = 16;
  localparam int unsigned BE_W     = 4;
  localparam int unsigned NPORTS   = 3;
  localparam int unsigned FC_W     = 4;
  localparam int unsigned MAC_W    = 48;
  localparam int unsigned MACL_W   = 32;
  localparam int unsigned MACH_W   = 16;
  // system register byte offsets
  localparam logic [7:0] OFF_DATA  = 8'h00;
  localparam logic [7:0] OFF_CMD   = 8'h04;
  localparam logic [7:0] OFF_FC0   = 8'h08;
  localparam logic [7:0] OFF_STEP  = 8'h04;
  localparam logic [7:0] OFF_MACL  = 8'h14;
  localparam logic [7:0] OFF_MACH  = 8'h18;
  localparam logic [7:0] OFF_WIN   = 8'h40;
  localparam logic [7:0] WIN_MASK  = 8'h1c;
  localparam int unsigned WIN_IDX_LSB = 2;
  localparam int unsigned WIN_IDX_W   = 3;
  localparam int unsigned WIN_WORDS   = 8;
  // command register fields
  localparam int unsigned CMD_BUSY = 31;
  localparam int unsigned CMD_RD   = 30;
  localparam int unsigned CMD_INC  = 29;
  localparam int unsigned CMD_DEC  = 28;
  localparam int unsigned CMD_BE   = 16;
  localparam int unsigned CMD_ADDR = 0;
  localparam logic [31:0] CMD_WMASK = 32'hf00f_ffff;
  localparam logic [31:0] CMD_RST   = 32'h0000_0000;
  localparam logic [31:0] DATA_RST  = 32'h0000_0000;
  localparam logic [3:0]  FC_RST    = 4'h0;
  localparam logic [47:0] MAC_RST   = 48'h0000_0000_0000;
  localparam logic [3:0]  BE_ALL    = 4'hf;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  // fixed subset of internal registers seen through the direct window
  localparam logic [15:0] WIN_MAP [WIN_WORDS] = '{
    16'h0000, 16'h0001, 16'h0002, 16'h0003,
    16'h0040, 16'h0041, 16'h0042, 16'h0043
  };
  typedef enum logic [1:0] {
    SCI_IDLE   = 2'b00,
    SCI_ISSUE  = 2'b01,
    SCI_FINISH = 2'b10
  } sci_state_t;
endpackage
`default_nettype wire

// ### hdl/sci_mem_if.sv
// interface: request and answer path to the internal switch register store
`default_nettype none
interface sci_mem_if #(parameter int unsigned AW = 8);
  logic          req;
  logic          wr;
  logic [AW-1:0] addr;
  logic [3:0]    be;
  logic [31:0]   wdata;
  logic [31:0]   rdata;
  modport ctl (output req, output wr, output addr, output be, output wdata, input rdata);
  modport mem (input req, input wr, input addr, input be, input wdata, output rdata);
endinterface
`default_nettype wire

// ### hdl/sci_csr_mem.sv
// module: internal switch register store with byte-lane writes
`default_nettype none
module sci_csr_mem #(
  parameter int unsigned AW = 8
) (
  input  wire logic pclk,
  sci_mem_if.mem    bus
);
  logic [31:0] mem_q [2**AW];
  logic [31:0] rdata_q;

  always_ff @(posedge pclk) begin
    if (bus.req && bus.wr) begin
      for (int b = 0; b < sci_pkg::BE_W; b++) begin
        if (bus.be[b]) begin
          mem_q[bus.addr][8*b +: 8] <= bus.wdata[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (bus.req && !bus.wr) begin
      rdata_q <= mem_q[bus.addr];
    end
  end

  assign bus.rdata = rdata_q;
endmodule
`default_nettype wire

// ### hdl/sci_bridge.sv
// module: APB bridge to the internal switch registers, direct and indirect access
`default_nettype none
module sci_bridge #(
  parameter int unsigned MEM_AW = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cycle_busy_flag,
  output logic      [11:0] port_flow_ctrl,
  output logic      [47:0] switch_mac_addr
);
  sci_mem_if #(.AW(MEM_AW)) mbus ();

  sci_csr_mem #(.AW(MEM_AW)) u_mem (
    .pclk (pclk),
    .bus  (mbus)
  );

  sci_pkg::sci_state_t state_q;
  logic [31:0] indirect_data_reg_q;
  logic [31:0] indirect_command_reg_q;
  logic [3:0]  fc_q [sci_pkg::NPORTS];
  logic [47:0] mac_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] rmux;

  // command register fields
  logic        busy;
  logic        read_write_select;
  logic        auto_step_up;
  logic        auto_step_down;
  logic        auto_step;
  logic [3:0]  byte_lane_enables;
  logic [15:0] target_register_address;
  logic [15:0] stepped_addr;

  assign busy                    = indirect_command_reg_q[sci_pkg::CMD_BUSY];
  assign read_write_select       = indirect_command_reg_q[sci_pkg::CMD_RD];
  assign auto_step_up            = indirect_command_reg_q[sci_pkg::CMD_INC];
  assign auto_step_down          = indirect_command_reg_q[sci_pkg::CMD_DEC];
  assign auto_step               = auto_step_up || auto_step_down;
  assign byte_lane_enables       = indirect_command_reg_q[sci_pkg::CMD_BE +: sci_pkg::BE_W];
  assign target_register_address = indirect_command_reg_q[sci_pkg::CMD_ADDR +: sci_pkg::CADDR_W];
  // up wins when both step bits are set
  assign stepped_addr = auto_step_up ? target_register_address + sci_pkg::ADDR_STEP
                                     : target_register_address - sci_pkg::ADDR_STEP;

  // bus phases
  logic setup, acc, wr_acc, rd_acc;
  assign setup  = psel && !penable;
  assign acc    = psel && penable && pready_q;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;

  // address decode
  logic hit_data, hit_cmd, hit_macl, hit_mach, hit_win, hit_fc_any, hit_any;
  logic [2:0] fc_hit;
  logic [2:0] win_idx;
  assign hit_data = (paddr == sci_pkg::OFF_DATA);
  assign hit_cmd  = (paddr == sci_pkg::OFF_CMD);
  assign hit_macl = (paddr == sci_pkg::OFF_MACL);
  assign hit_mach = (paddr == sci_pkg::OFF_MACH);
  assign hit_win  = ((paddr & ~sci_pkg::WIN_MASK) == sci_pkg::OFF_WIN);
  assign win_idx  = paddr[sci_pkg::WIN_IDX_LSB +: sci_pkg::WIN_IDX_W];

  for (genvar p = 0; p < sci_pkg::NPORTS; p++) begin : g_fc
    assign fc_hit[p] = (paddr == sci_pkg::OFF_FC0 + 8'(p) * sci_pkg::OFF_STEP);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fc_q[p] <= sci_pkg::FC_RST;
      end else if (wr_acc && fc_hit[p]) begin
        fc_q[p] <= pwdata[sci_pkg::FC_W-1:0];
      end
    end

    assign port_flow_ctrl[p*sci_pkg::FC_W +: sci_pkg::FC_W] = fc_q[p];
  end

  assign hit_fc_any = |fc_hit;
  assign hit_any    = hit_data || hit_cmd || hit_macl || hit_mach || hit_win || hit_fc_any;

  // cycle launch conditions; data, command and window writes are ignored while a cycle runs
  logic start_cmd, start_wseq, start_win, start_rseq, launch, finish;
  assign start_cmd  = wr_acc && hit_cmd && !busy && pwdata[sci_pkg::CMD_BUSY];
  assign start_wseq = wr_acc && hit_data && !busy && auto_step && !read_write_select;
  assign start_win  = wr_acc && hit_win && !busy;
  assign start_rseq = rd_acc && hit_data && !busy && auto_step && read_write_select;
  assign launch     = start_cmd || start_wseq || start_win || start_rseq;
  assign finish     = (state_q == sci_pkg::SCI_FINISH);

  // cycle sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= sci_pkg::SCI_IDLE;
    end else begin
      case (state_q)
        sci_pkg::SCI_IDLE: begin
          if (launch) begin
            state_q <= sci_pkg::SCI_ISSUE;
          end
        end
        sci_pkg::SCI_ISSUE: begin
          state_q <= sci_pkg::SCI_FINISH;
        end
        sci_pkg::SCI_FINISH: begin
          state_q <= sci_pkg::SCI_IDLE;
        end
        default: begin
          state_q <= sci_pkg::SCI_IDLE;
        end
      endcase
    end
  end

  // internal store request, issued only from the sequencer
  assign mbus.req   = (state_q == sci_pkg::SCI_ISSUE);
  assign mbus.wr    = !read_write_select;
  assign mbus.addr  = target_register_address[MEM_AW-1:0];
  assign mbus.be    = byte_lane_enables;
  assign mbus.wdata = indirect_data_reg_q;

  // command register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indirect_command_reg_q <= sci_pkg::CMD_RST;
    end else if (start_win) begin
      indirect_command_reg_q[sci_pkg::CMD_ADDR +: sci_pkg::CADDR_W] <=
        sci_pkg::WIN_MAP[win_idx];
      indirect_command_reg_q[sci_pkg::CMD_BE +: sci_pkg::BE_W] <= sci_pkg::BE_ALL;
      indirect_command_reg_q[sci_pkg::CMD_RD]   <= 1'b0;
      indirect_command_reg_q[sci_pkg::CMD_BUSY] <= 1'b1;
    end else if (wr_acc && hit_cmd && !busy) begin
      indirect_command_reg_q <= pwdata & sci_pkg::CMD_WMASK;
    end else if (start_wseq) begin
      indirect_command_reg_q[sci_pkg::CMD_BUSY] <= 1'b1;
    end else if (start_rseq) begin
      indirect_command_reg_q[sci_pkg::CMD_ADDR +: sci_pkg::CADDR_W] <= stepped_addr;
      indirect_command_reg_q[sci_pkg::CMD_BUSY] <= 1'b1;
    end else if (finish) begin
      indirect_command_reg_q[sci_pkg::CMD_BUSY] <= 1'b0;
      if (!read_write_select && auto_step) begin
        indirect_command_reg_q[sci_pkg::CMD_ADDR +: sci_pkg::CADDR_W] <= stepped_addr;
      end
    end
  end

  // data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indirect_data_reg_q <= sci_pkg::DATA_RST;
    end else if (wr_acc && (hit_data || hit_win) && !busy) begin
      indirect_data_reg_q <= pwdata;
    end else if (finish && read_write_select) begin
      indirect_data_reg_q <= mbus.rdata;
    end
  end

  // switch MAC address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_q <= sci_pkg::MAC_RST;
    end else if (wr_acc && hit_macl) begin
      mac_q[sci_pkg::MACL_W-1:0] <= pwdata;
    end else if (wr_acc && hit_mach) begin
      mac_q[sci_pkg::MAC_W-1:sci_pkg::MACL_W] <= pwdata[sci_pkg::MACH_W-1:0];
    end
  end

  // read mux; the window reads as zero
  always_comb begin
    rmux = '0;
    if (hit_data) begin
      rmux = indirect_data_reg_q;
    end else if (hit_cmd) begin
      rmux = indirect_command_reg_q;
    end else if (hit_macl) begin
      rmux = mac_q[sci_pkg::MACL_W-1:0];
    end else if (hit_mach) begin
      rmux = {16'h0000, mac_q[sci_pkg::MAC_W-1:sci_pkg::MACL_W]};
    end else begin
      for (int p = 0; p < sci_pkg::NPORTS; p++) begin
        if (fc_hit[p]) begin
          rmux = {28'h000_0000, fc_q[p]};
        end
      end
    end
  end

  // answer registered in the setup cycle, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !hit_any;
      prdata_q  <= (setup && !pwrite) ? rmux : '0;
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign cycle_busy_flag = busy;
  assign switch_mac_addr = mac_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_launch_sets_busy: assert property (
    launch |=> busy && state_q == sci_pkg::SCI_ISSUE)
    else $error("cycle launch did not set busy");

  a_busy_two_cycles: assert property (
    $rose(busy) |-> busy ##1 busy ##1 !busy)
    else $error("busy did not clear two cycles after launch");

  a_store_only_seq: assert property (
    mbus.req |-> busy && $past(state_q) == sci_pkg::SCI_IDLE)
    else $error("internal store reached outside a cycle");

  a_window_fields: assert property (
    start_win |=> busy && !read_write_select && byte_lane_enables == sci_pkg::BE_ALL
      && target_register_address == sci_pkg::WIN_MAP[$past(win_idx)]
      && mbus.req && mbus.wdata == $past(pwdata))
    else $error("window write set wrong command fields");

  a_read_data_valid: assert property (
    (state_q == sci_pkg::SCI_ISSUE && read_write_select) |=>
      ##1 !busy && indirect_data_reg_q == $past(mbus.rdata))
    else $error("read data not valid when busy cleared");

  a_wseq_step: assert property (
    (finish && !read_write_select && auto_step_up) |=>
      target_register_address == $past(target_register_address) + sci_pkg::ADDR_STEP)
    else $error("sequential write address not stepped");

  a_rseq_relaunch: assert property (
    (start_rseq && auto_step_down && !auto_step_up) |=> busy && mbus.req && !mbus.wr
      && target_register_address == $past(target_register_address) - sci_pkg::ADDR_STEP)
    else $error("sequential read did not step and relaunch");

  a_wseq_launch: assert property (
    start_wseq |=> mbus.req && mbus.wr && mbus.wdata == $past(pwdata))
    else $error("sequential data write did not launch a write");

  a_flow_ctrl_reg: assert property (
    (wr_acc && fc_hit[0]) |=> port_flow_ctrl[sci_pkg::FC_W-1:0] == $past(pwdata[3:0]))
    else $error("port flow control register not written");

  a_lane_enables: assert property (
    (start_cmd && !pwdata[sci_pkg::CMD_RD]) |=>
      mbus.req && mbus.be == $past(pwdata[sci_pkg::CMD_BE +: sci_pkg::BE_W]))
    else $error("byte enables not carried to the write");

  a_pready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  a_unmapped_error: assert property (
    (setup && !hit_any) |=> pready && pslverr)
    else $error("unmapped address not answered with an error");

  a_window_read_zero: assert property (
    (setup && !pwrite && hit_win) |=> pready && prdata == '0)
    else $error("window read did not return zero");

  a_write_no_data: assert property (
    (setup && pwrite) |=> pready && prdata == '0)
    else $error("write access drove read data");

  a_mac_high_reg: assert property (
    (wr_acc && hit_mach) |=>
      switch_mac_addr[sci_pkg::MAC_W-1:sci_pkg::MACL_W] == $past(pwdata[sci_pkg::MACH_W-1:0]))
    else $error("MAC high register not written");

  a_fc_port_two: assert property (
    (wr_acc && fc_hit[2]) |=>
      port_flow_ctrl[2*sci_pkg::FC_W +: sci_pkg::FC_W] == $past(pwdata[sci_pkg::FC_W-1:0]))
    else $error("last port flow control register not written");

  a_read_no_step: assert property (
    (finish && read_write_select) |=>
      target_register_address == $past(target_register_address))
    else $error("read completion moved the address");

  a_wseq_step_down: assert property (
    (finish && !read_write_select && auto_step_down && !auto_step_up) |=>
      target_register_address == $past(target_register_address) - sci_pkg::ADDR_STEP)
    else $error("sequential write address not stepped down");

  a_finish_idle: assert property (
    finish |=> state_q == sci_pkg::SCI_IDLE && !busy)
    else $error("sequencer did not return to idle with busy clear");

  c_single_write: cover property (start_cmd && !pwdata[sci_pkg::CMD_RD] ##3 !busy);
  c_single_read:  cover property (start_cmd && pwdata[sci_pkg::CMD_RD] ##3 !busy);
  c_seq_write:    cover property (start_wseq ##3 !busy);
  c_seq_read:     cover property (start_rseq ##[3:40] start_rseq);
  c_window_write: cover property (start_win ##3 !busy);
endmodule
`default_nettype wire

// ### verif/switch_csr_indirect_access_tb.sv
// testbench: apb checks of the indirect switch register bridge
`default_nettype none
module switch_csr_indirect_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DAT = sci_pkg::OFF_DATA;
  localparam logic [7:0] CMD = sci_pkg::OFF_CMD;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cycle_busy_flag;
  logic [11:0] port_flow_ctrl;
  logic [47:0] switch_mac_addr;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [31:0] mem [256];
  logic [31:0] rd;
  logic        err;
  int          busy_rises = 0;
  logic        busy_prev = 1'b0;
  always #4 pclk = ~pclk;
  sci_bridge #(.MEM_AW(8)) sci_bridge_inst (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .cycle_busy_flag (cycle_busy_flag),
    .port_flow_ctrl  (port_flow_ctrl),
    .switch_mac_addr (switch_mac_addr)
  );
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    busy_prev <= cycle_busy_flag;
    if (cycle_busy_flag === 1'b1 && busy_prev !== 1'b1) busy_rises <= busy_rises + 1;
    if (cyc == 30000) begin
      bad_count++;
      $display("ERROR at %0t: run hangs", $time);
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk_bit(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the access edge settle before callers look at outputs
    @(negedge pclk);
  endtask
  // host polls busy before any new start
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, CMD, 32'h0);
      n++;
    end while (rd[31] !== 1'b0 && n < 20);
    chk_bit(rd[31], 1'b0);
  endtask
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] v, logic [3:0] be);
    for (int i = 0; i < 4; i++) merge[8*i +: 8] = be[i] ? v[8*i +: 8] : o[8*i +: 8];
  endfunction
  task automatic single_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
    int r0;
    apb(1'b1, DAT, d);
    r0 = busy_rises;
    apb(1'b1, CMD, {4'h8, 8'h0, be, a});
    wait_idle();
    chk_bit(busy_rises == r0 + 1, 1'b1);
    chk_word(rd, {12'h0, be, a});
  endtask
  task automatic single_read(input logic [15:0] a);
    apb(1'b1, CMD, {4'hc, 12'h0, a});
    wait_idle();
    chk_word(rd, {4'h4, 12'h0, a});
    apb(1'b0, DAT, 32'h0);
    chk_word(rd, mem[a[7:0]]);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  initial begin
    logic [31:0] v;
    logic [31:0] w;
    logic [15:0] a;
    logic [3:0]  be;
    logic [11:0] fc;
    void'($urandom(32'h7c3eca71));
    for (int i = 0; i < 256; i++) mem[i] = 'x;
    repeat (10) @(posedge pclk);
    chk_word(prdata, 32'h0);
    chk_bit(pready, 1'b0);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, DAT, 32'h0);
    chk_word(rd, sci_pkg::DATA_RST);
    apb(1'b0, CMD, 32'h0);
    chk_word(rd, sci_pkg::CMD_RST);
    tend("reset");
    fc = 12'h0;
    for (int k = 0; k < 3; k++) begin
      v = $urandom;
      fc[4*k +: 4] = v[3:0];
      apb(1'b1, 8'(sci_pkg::OFF_FC0 + 4*k), {28'h0, v[3:0]});
      chk_word({20'h0, port_flow_ctrl}, {20'h0, fc});
    end
    v = $urandom;
    w = $urandom;
    apb(1'b1, sci_pkg::OFF_MACL, v);
    apb(1'b1, sci_pkg::OFF_MACH, w);
    chk_word(switch_mac_addr[31:0], v);
    chk_word({16'h0, switch_mac_addr[47:32]}, {16'h0, w[15:0]});
    apb(1'b1, 8'h30, $urandom);
    chk_bit(err, 1'b1);
    apb(1'b0, 8'h30, 32'h0);
    chk_bit(err, 1'b1);
    apb(1'b0, sci_pkg::OFF_WIN, 32'h0);
    chk_word(rd, 32'h0);
    tend("system space");
    for (int k = 0; k < 6; k++) begin
      a = 16'h0080 + 16'(k);
      v = $urandom;
      w = $urandom;
      be = (k == 0) ? 4'h0 : 4'($urandom);
      single_write(a, v, 4'hf);
      single_write(a, w, be);
      mem[a[7:0]] = merge(v, w, be);
      single_read(a);
    end
    tend("single");
    for (int k = 0; k < 2; k++) begin
      a = (k == 0) ? 16'h00a0 : 16'h00b0;
      apb(1'b1, CMD, {2'b00, k == 0, k == 1, 8'h0, 4'hf, a});
      for (int j = 0; j < 4; j++) begin
        v = $urandom;
        apb(1'b1, DAT, v);
        mem[a[7:0]] = v;
        wait_idle();
        a = (k == 0) ? a + 16'h1 : a - 16'h1;
        chk_word(rd, {2'b00, k == 0, k == 1, 8'h0, 4'hf, a});
      end
    end
    apb(1'b1, CMD, 32'h0);
    tend("sequential write");
    for (int k = 0; k < 8; k++) begin
      v = $urandom;
      apb(1'b1, 8'(sci_pkg::OFF_WIN + 4*k), v);
      wait_idle();
      chk_word(rd, {12'h0, 4'hf, sci_pkg::WIN_MAP[k]});
      mem[sci_pkg::WIN_MAP[k][7:0]] = v;
      apb(1'b0, DAT, 32'h0);
      chk_word(rd, v);
    end
    tend("window");
    for (int k = 0; k < 2; k++) begin
      a = (k == 0) ? 16'h00a0 : 16'h00b0;
      apb(1'b1, CMD, {2'b11, k == 0, k == 1, 12'h0, a});
      for (int j = 0; j < 4; j++) begin
        wait_idle();
        if (j == 3) apb(1'b1, CMD, {4'h4, 12'h0, a});
        else chk_word(rd, {2'b01, k == 0, k == 1, 12'h0, a});
        apb(1'b0, DAT, 32'h0);
        chk_word(rd, mem[a[7:0]]);
        if (j < 3) a = (k == 0) ? a + 16'h1 : a - 16'h1;
      end
      wait_idle();
      chk_word(rd, {4'h4, 12'h0, a});
    end
    tend("sequential read");
    for (int i = 0; i < 256; i++) if (!$isunknown(mem[i])) single_read(16'(i));
    tend("readback");
    conclude();
  end
endmodule
`default_nettype wire
